/* rtl/pio_port_cfg.svh */
`ifndef PIO_PORT_CFG_SVH
`define PIO_PORT_CFG_SVH
// Bus shape
`define PIO_DATA_W        16
`define PIO_ADDR_W        7
// Address map (word address, bits 7:1 of the byte address)
`define PIO_ADDR_RX_DATA  7'h00
`define PIO_ADDR_RX_STS   7'h20
`define PIO_ADDR_TX_STS   7'h24
`define PIO_ADDR_CSR_BASE 7'h28
`define PIO_ADDR_CTR_LO   7'h3e
`define PIO_ADDR_CTR_HI   7'h3f
// Direct mode keeps only these low address bits
`define PIO_DIRECT_MASK   7'h03
// Burst length limit in register mode
`define PIO_BURST_MAX     16
// Value read from empty FIFOs or unmapped addresses
`define PIO_IDLE_DATA     16'h0000
// Minimum strobe high time, ns, and at 10 ns per clock
`define PIO_TCSH_NS       13
`define PIO_CLK_NS        10
`define PIO_TCSH_CYC      ((`PIO_TCSH_NS + `PIO_CLK_NS - 1) / `PIO_CLK_NS)
`define PIO_FIFO_DEPTH    8
`endif

/* rtl/pio_port_pkg.sv */
package pio_port_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE
  } cycle_state_t;
  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_RX_DATA,
    SRC_RX_STS,
    SRC_TX_STS
  } read_src_t;
endpackage

/* rtl/stream_if.sv */
`timescale 1ns/1ps
interface stream_if #(parameter int W = 16);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* rtl/word_fifo.sv */
`timescale 1ns/1ps
module word_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Fill and drain sides
  stream_if.snk    wr,
  stream_if.src    rd
);
  localparam int AW = $clog2(DEPTH);
  // Pointer wrap and the full test rely on a power-of-two depth
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
    $error("DEPTH must be a power of two");
  end
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wptr_reg;
  logic [AW:0]  rptr_reg;
  logic         full;
  logic         empty;
  logic         push;
  logic         pop;

  // Extra pointer bit tells full from empty
  assign empty    = (wptr_reg == rptr_reg);
  assign full     = (wptr_reg[AW] != rptr_reg[AW]) && (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]);
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data  = mem[rptr_reg[AW-1:0]];
  assign push     = wr.valid && !full;
  assign pop      = rd.ready && !empty;

  // Storage write
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wptr_reg[AW-1:0]] <= wr.data;
    end
  end

  // Pointers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else begin
      if (push) begin
        wptr_reg <= wptr_reg + 1'b1;
      end
      if (pop) begin
        rptr_reg <= rptr_reg + 1'b1;
      end
    end
  end
endmodule // word_fifo

/* rtl/pio_port.sv */
// Functional notes
// - Single reads return CSR, RX data, RX status or TX status by address.
// - Counter value is snapshotted at read start and held all cycle.
// - Read starts when select and read strobe both low; ends when either rises.
// - Burst reads keep strobes low; new address gives new data, up to 16.
// - FIFO select high makes every read return RX data FIFO words.
// - Direct mode reads RX data for any address; a change in any of bits 7:1 is a step.
// - Direct burst allows unlimited reads, one FIFO pop per address step.
// - FIFO select is registered with the address lines, but only an address change is a step.
// - All writes use one write cycle type framed by select and write strobe.
// - Write starts when select and write strobe both low; ends when either rises.
// - Data bus is 16 bits for every cycle type.
`timescale 1ns/1ps
`include "pio_port_cfg.svh"
module pio_port #(
  parameter int DW         = `PIO_DATA_W,
  parameter int BURST_MAX  = `PIO_BURST_MAX,
  parameter int FIFO_DEPTH = `PIO_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   rstn,
  // Host bus pins, word address bits 7:1
  input  wire logic                   chip_select_low,
  input  wire logic                   read_strobe_low,
  input  wire logic                   write_strobe_low,
  input  wire logic                   fifo_sel,
  input  wire logic [`PIO_ADDR_W-1:0] addr,
  input  wire logic [DW-1:0]          data_in,
  output      logic [DW-1:0]          data_out,
  output      logic                   data_oe,
  // RX data words from the receive path
  input  wire logic                   rx_data_valid,
  output      logic                   rx_data_ready,
  input  wire logic [DW-1:0]          rx_data,
  // RX and TX status words
  input  wire logic                   rx_sts_valid,
  input  wire logic [DW-1:0]          rx_sts,
  output      logic                   rx_sts_pop,
  input  wire logic                   tx_sts_valid,
  input  wire logic [DW-1:0]          tx_sts,
  output      logic                   tx_sts_pop,
  // Live counter to be snapshotted, 32 bits as two words
  input  wire logic [2*DW-1:0]        counter,
  // CSR side, 8 words
  input  wire logic [8*DW-1:0]        csr_rdata,
  output      logic                   csr_we,
  output      logic [2:0]             csr_waddr,
  output      logic [DW-1:0]          csr_wdata,
  // Strobe high time violation seen
  output      logic                   tcsh_violation
);
  // Burst count saturates at 31, so a longer limit could never be reached
  if (DW != 16) begin : g_dw_check
    $error("Host data bus is 16 bits");
  end
  if (BURST_MAX < 1 || BURST_MAX > 31) begin : g_burst_check
    $error("BURST_MAX must lie between 1 and 31");
  end

  pio_port_pkg::cycle_state_t state_reg;
  pio_port_pkg::read_src_t    src;
  logic                       rd_act;
  logic                       wr_act;
  logic [`PIO_ADDR_W-1:0]     addr_reg;
  logic                       fsel_reg;
  logic [DW-1:0]              wdata_reg;
  logic [2*DW-1:0]            snap_reg;
  logic [DW-1:0]              dout_reg;
  logic [4:0]                 burst_reg;
  logic [3:0]                 high_reg;
  logic                       step;
  logic                       first;
  logic [`PIO_ADDR_W-1:0]     eff_addr;
  logic [DW-1:0]              fifo_word;
  logic                       fifo_take;

  stream_if #(.W(DW)) fill_if ();
  stream_if #(.W(DW)) drain_if ();

  // Receive words are staged so the host sees a word ready at strobe time
  assign fill_if.valid  = rx_data_valid;
  assign fill_if.data   = rx_data;
  assign rx_data_ready  = fill_if.ready;
  assign fifo_word      = drain_if.data;
  assign drain_if.ready = fifo_take;

  word_fifo #(.W(DW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk (mclk),
    .rstn (rstn),
    .wr   (fill_if),
    .rd   (drain_if)
  );

  // Cycle framing from both strobes together
  assign rd_act = !chip_select_low && !read_strobe_low;
  assign wr_act = !chip_select_low && !write_strobe_low;
  assign first  = (state_reg == pio_port_pkg::ST_IDLE) && rd_act;
  assign step   = (state_reg == pio_port_pkg::ST_READ) && rd_act && (addr != addr_reg);

  // Direct mode masks the upper address bits, select sampled with address
  assign eff_addr = fifo_sel ? (addr & `PIO_DIRECT_MASK) : addr;

  // Source of the word for the current address
  always_comb begin
    src = pio_port_pkg::SRC_NONE;
    if (fifo_sel) begin
      src = pio_port_pkg::SRC_RX_DATA;
    end else if (eff_addr < `PIO_ADDR_RX_STS) begin
      src = pio_port_pkg::SRC_RX_DATA;
    end else if (eff_addr == `PIO_ADDR_RX_STS) begin
      src = pio_port_pkg::SRC_RX_STS;
    end else if (eff_addr == `PIO_ADDR_TX_STS) begin
      src = pio_port_pkg::SRC_TX_STS;
    end
  end

  // Pops happen once per access, at cycle start or on each address step
  assign fifo_take  = (first || step) && (src == pio_port_pkg::SRC_RX_DATA)
                      && drain_if.valid;
  assign rx_sts_pop = (first || step) && (src == pio_port_pkg::SRC_RX_STS) && rx_sts_valid;
  assign tx_sts_pop = (first || step) && (src == pio_port_pkg::SRC_TX_STS) && tx_sts_valid;

  // Cycle state
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= pio_port_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        pio_port_pkg::ST_IDLE: begin
          if (rd_act) begin
            state_reg <= pio_port_pkg::ST_READ;
          end else if (wr_act) begin
            state_reg <= pio_port_pkg::ST_WRITE;
          end
        end
        pio_port_pkg::ST_READ: begin
          if (!rd_act) begin
            state_reg <= pio_port_pkg::ST_IDLE;
          end
        end
        pio_port_pkg::ST_WRITE: begin
          if (!wr_act) begin
            state_reg <= pio_port_pkg::ST_IDLE;
          end
        end
        default: state_reg <= pio_port_pkg::ST_IDLE;
      endcase
    end
  end

  // Address and select follow the bus while a cycle is open
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      addr_reg  <= '0;
      fsel_reg  <= 1'b0;
      wdata_reg <= '0;
    end else if (rd_act || wr_act) begin
      addr_reg  <= addr;
      fsel_reg  <= fifo_sel;
      wdata_reg <= data_in;
    end
  end

  // Counter snapshot only at read start keeps both halves coherent
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      snap_reg <= '0;
    end else if (first) begin
      snap_reg <= counter;
    end
  end

  // Burst length count; beyond the limit in register mode reads idle data
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      burst_reg <= '0;
    end else if (first) begin
      burst_reg <= 5'h01;
    end else if (step && burst_reg < 5'h1f) begin
      burst_reg <= burst_reg + 5'h01;
    end
  end

  // Read word register, loaded at start and on every address step
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dout_reg <= `PIO_IDLE_DATA;
    end else if (first || step) begin
      if (!fifo_sel && step && burst_reg >= 5'(BURST_MAX)) begin
        dout_reg <= `PIO_IDLE_DATA;
      end else begin
        case (src)
          pio_port_pkg::SRC_RX_DATA: dout_reg <= drain_if.valid ? fifo_word : `PIO_IDLE_DATA;
          pio_port_pkg::SRC_RX_STS:  dout_reg <= rx_sts_valid ? rx_sts : `PIO_IDLE_DATA;
          pio_port_pkg::SRC_TX_STS:  dout_reg <= tx_sts_valid ? tx_sts : `PIO_IDLE_DATA;
          default: begin
            if (eff_addr == `PIO_ADDR_CTR_LO) begin
              dout_reg <= first ? counter[DW-1:0] : snap_reg[DW-1:0];
            end else if (eff_addr == `PIO_ADDR_CTR_HI) begin
              dout_reg <= first ? counter[2*DW-1:DW] : snap_reg[2*DW-1:DW];
            end else if (eff_addr >= `PIO_ADDR_CSR_BASE
                         && eff_addr < `PIO_ADDR_CSR_BASE + 7'h08) begin
              dout_reg <= csr_rdata[DW*(3'(eff_addr - `PIO_ADDR_CSR_BASE)) +: DW];
            end else begin
              dout_reg <= `PIO_IDLE_DATA;
            end
          end
        endcase
      end
    end
  end

  // Bus driven only while the read is open
  assign data_out = dout_reg;
  assign data_oe  = (state_reg == pio_port_pkg::ST_READ) && rd_act;

  // Write takes effect once, at the first deasserting edge
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      csr_we    <= 1'b0;
      csr_waddr <= '0;
      csr_wdata <= '0;
    end else begin
      csr_we <= 1'b0;
      if (state_reg == pio_port_pkg::ST_WRITE && !wr_act && !fsel_reg
          && addr_reg >= `PIO_ADDR_CSR_BASE && addr_reg < `PIO_ADDR_CSR_BASE + 7'h08) begin
        csr_we    <= 1'b1;
        csr_waddr <= 3'(addr_reg - `PIO_ADDR_CSR_BASE);
        csr_wdata <= wdata_reg;
      end
    end
  end

  // Host side timing watch: strobes high shorter than the minimum
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      high_reg       <= 4'hf;
      tcsh_violation <= 1'b0;
    end else if (rd_act || wr_act) begin
      if (state_reg == pio_port_pkg::ST_IDLE && high_reg < 4'(`PIO_TCSH_CYC)) begin
        tcsh_violation <= 1'b1;
      end
      high_reg <= 4'h0;
    end else if (high_reg != 4'hf) begin
      high_reg <= high_reg + 4'h1;
    end
  end
endmodule // pio_port

/* tb/pio_port_properties.sv */
`timescale 1ns/1ps
module pio_port_properties (
  // Clock, reset and host strobes
  input wire logic mclk,
  input wire logic rstn,
  input wire logic chip_select_low,
  input wire logic read_strobe_low,
  input wire logic write_strobe_low,
  // Watched outputs and their causes
  input wire logic data_oe,
  input wire logic rx_sts_valid,
  input wire logic rx_sts_pop,
  input wire logic tx_sts_valid,
  input wire logic tx_sts_pop,
  input wire logic csr_we,
  input wire logic tcsh_violation
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Open cycles; a read only counts with the write strobe idle
  wire rd_on   = !chip_select_low && !read_strobe_low;
  wire wr_on   = !chip_select_low && !write_strobe_low;
  wire rd_only = rd_on && write_strobe_low;
  a_oe_needs_read: assert property (data_oe |-> rd_on)
    else $error("data bus driven outside an open read");
  a_oe_opens: assert property ((!rd_on && write_strobe_low) ##1 rd_only [*2] |-> data_oe)
    else $error("data bus not driven one cycle after read start");
  a_oe_holds_burst: assert property (data_oe ##1 rd_on |-> data_oe)
    else $error("data bus dropped while read strobes stay low");
  a_rx_pop_cause: assert property (rx_sts_pop |-> rd_on && rx_sts_valid)
    else $error("rx status popped without a read of a full source");
  a_tx_pop_cause: assert property (tx_sts_pop |-> rd_on && tx_sts_valid)
    else $error("tx status popped without a read of a full source");
  a_we_one_pulse: assert property (csr_we |=> !csr_we)
    else $error("register write pulse longer than one cycle");
  a_we_after_end: assert property (csr_we |-> !$past(wr_on) && ($past(wr_on, 2) || $past(wr_on, 3)))
    else $error("register write not tied to the end of a write cycle");
  a_no_we_read: assert property (data_oe |-> !csr_we)
    else $error("register write during a read");
  a_tcsh_sticky: assert property (tcsh_violation |=> tcsh_violation)
    else $error("strobe high time flag cleared by itself");
endmodule // pio_port_properties

/* tb/host_model.sv */
`timescale 1ns/1ps
module host_model (
  // Clock and read data
  input  wire logic        mclk,
  input  wire logic [15:0] data_out,
  input  wire logic        data_oe,
  // Host bus pins
  output logic             chip_select_low,
  output logic             read_strobe_low,
  output logic             write_strobe_low,
  output logic             fifo_sel,
  output logic [6:0]       addr,
  output logic [15:0]      data_in,
  // Captured word and its toggle
  output logic [15:0]      rd_word,
  output logic             rd_seen
);
  // Idle bus at time zero
  initial begin
    {chip_select_low, read_strobe_low, write_strobe_low, fifo_sel} = 4'he;
    addr = 7'h00;
    data_in = 16'h5a5a;
    rd_word = 16'h0000;
    rd_seen = 1'b0;
  end
  // One read step; inside an open burst it is an address change
  task automatic rd(input logic fs, input logic [6:0] a);
    fifo_sel = fs;
    addr = a;
    chip_select_low = 1'b0;
    read_strobe_low = 1'b0;
    repeat (5) @(negedge mclk); // Full cycle time per step
    rd_word = data_oe ? data_out : ~data_out; // Released bus reads back inverted
    rd_seen = ~rd_seen;
  endtask
  // Release; address lines flip so a stale value never looks valid
  task automatic close(input int n = 3);
    {chip_select_low, read_strobe_low, write_strobe_low} = 3'h7;
    addr = ~addr;
    fifo_sel = ~fifo_sel;
    repeat (n) @(negedge mclk); // High time between cycles
  endtask
  // One 16-bit write cycle
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    fifo_sel = 1'b0;
    addr = a;
    data_in = d;
    chip_select_low = 1'b0;
    write_strobe_low = 1'b0;
    repeat (4) @(negedge mclk);
    data_in = ~d;
    close();
  endtask
endmodule // host_model

/* tb/pio_port_tb.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
  $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module pio_port_tb;
  logic         mclk = 1'b0;
  logic         rstn = 1'b0;
  logic         chip_select_low, read_strobe_low, write_strobe_low, fifo_sel, rd_seen;
  logic         data_oe, rx_data_valid, rx_data_ready, rx_sts_valid, rx_sts_pop;
  logic         tx_sts_valid, tx_sts_pop, csr_we, tcsh_violation;
  logic [6:0]   addr;
  logic [15:0]  data_in, data_out, rx_data, rx_sts, tx_sts, csr_wdata, rd_word, w;
  logic [2:0]   csr_waddr;
  logic [31:0]  counter, cnt, seed = 32'h00000045;
  logic [127:0] csr_rdata;
  logic [18:0]  q[$], e_rd, e_wr;
  logic [15:0]  fq[$];
  int           n_mismatch = 0, tests_run = 0, cyc = 0, n, n_pop = 0;

  always #5 mclk = ~mclk;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  pio_port pio_port_inst (.mclk, .rstn, .chip_select_low, .read_strobe_low, .write_strobe_low,
    .fifo_sel, .addr, .data_in, .data_out, .data_oe, .rx_data_valid, .rx_data_ready, .rx_data,
    .rx_sts_valid, .rx_sts, .rx_sts_pop, .tx_sts_valid, .tx_sts, .tx_sts_pop, .counter,
    .csr_rdata, .csr_we, .csr_waddr, .csr_wdata, .tcsh_violation);
  host_model host_model_inst (.mclk, .data_out, .data_oe, .chip_select_low, .read_strobe_low,
    .write_strobe_low, .fifo_sel, .addr, .data_in, .rd_word, .rd_seen);

  // Result watchers take the oldest note once, so a mismatch cannot eat a second one
  always @(rd_seen) if (rstn) begin
    e_rd = q.pop_front();
    `CHK({3'h0, rd_word}, e_rd)
  end
  always @(posedge mclk) if (csr_we === 1'b1) begin
    e_wr = q.pop_front();
    `CHK({csr_waddr, csr_wdata}, e_wr)
  end
  // Status pops counted at the edge that takes them
  always @(posedge mclk) if (rx_sts_pop === 1'b1 || tx_sts_pop === 1'b1) n_pop++;

  // Hang guard, well above the expected run
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (q.size() != 0) n_mismatch++;
    $display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    {rx_data_valid, rx_sts_valid, tx_sts_valid} = 3'h0;
    {rx_data, rx_sts, tx_sts, counter, csr_rdata} = '0;
    repeat (5) @(negedge mclk);
    rstn = 1'b1;
    `CHK({data_oe, data_out}, 17'h00000)
    csr_rdata = {xs(), xs(), xs(), xs()};
    // Single register reads, then a burst one step past its limit
    for (int k = 0; k < 8; k++) begin
      q.push_back({3'h0, csr_rdata[16*k+:16]});
      host_model_inst.rd(1'b0, 7'h28 + 7'(k));
      host_model_inst.close();
    end
    for (int k = 0; k < 17; k++) begin
      q.push_back(k < 16 ? {3'h0, csr_rdata[16*(k%8)+:16]} : 19'h0);
      host_model_inst.rd(1'b0, 7'h28 + 7'(k % 8));
    end
    host_model_inst.close();
    // Status words with data, then with the source empty
    {rx_sts, tx_sts} = xs();
    for (int k = 0; k < 4; k++) begin
      rx_sts_valid = k < 2;
      tx_sts_valid = k < 2;
      q.push_back(k < 2 ? {3'h0, k[0] ? tx_sts : rx_sts} : 19'h0);
      host_model_inst.rd(1'b0, k[0] ? 7'h24 : 7'h20);
      host_model_inst.close();
    end
    `CHK(n_pop, 2)
    // Counter changes mid-burst; the high half must come from the snapshot
    cnt = xs();
    counter = cnt;
    q.push_back({3'h0, cnt[15:0]});
    host_model_inst.rd(1'b0, 7'h3e);
    counter = ~cnt;
    q.push_back({3'h0, cnt[31:16]});
    host_model_inst.rd(1'b0, 7'h3f);
    host_model_inst.close();
    // Fill the receive buffer until it refuses
    n = 0;
    repeat (10) begin
      w = 16'(xs());
      rx_data = w;
      rx_data_valid = rx_data_ready;
      if (rx_data_ready) begin
        fq.push_back(w);
        n++;
      end
      @(negedge mclk);
    end
    rx_data_valid = 1'b0;
    `CHK(n, 8)
    // Register-mode pop, then a direct burst with random upper address bits
    q.push_back({3'h0, fq.pop_front()});
    host_model_inst.rd(1'b0, 7'h05);
    host_model_inst.close();
    for (int k = 0; k < 9; k++) begin
      cnt = xs();
      q.push_back(k < 7 ? {3'h0, fq[k]} : 19'h0);
      host_model_inst.rd(1'b1, {cnt[4:0], 2'(k)});
    end
    host_model_inst.close();
    `CHK(rx_data_ready, 1'b1)
    // Writes into the register range; one outside it must not pulse
    for (int k = 0; k < 8; k++) begin
      w = 16'(xs());
      q.push_back({3'(k), w});
      host_model_inst.wr(7'h28 + 7'(k), w);
    end
    host_model_inst.wr(7'h10, 16'hffff);
    repeat (4) @(negedge mclk);
    `CHK(tcsh_violation, 1'b0)
    // Strobes high for one cycle only between reads must raise the flag
    for (int k = 0; k < 2; k++) begin
      q.push_back({3'h0, csr_rdata[16*k+:16]});
      host_model_inst.rd(1'b0, 7'h28 + 7'(k));
      host_model_inst.close(k == 0 ? 1 : 3);
    end
    `CHK(tcsh_violation, 1'b1)
    `CHK(data_oe, 1'b0)
    end_sim();
  end
endmodule // pio_port_tb

bind pio_port pio_port_properties pio_port_properties_inst (.mclk, .rstn, .chip_select_low,
  .read_strobe_low, .write_strobe_low, .data_oe, .rx_sts_valid, .rx_sts_pop, .tx_sts_valid,
  .tx_sts_pop, .csr_we, .tcsh_violation);
